// ===== design/ssc_pkg.sv
package ssc_pkg;

   // =====================================================================
   // array geometry
   localparam int ADDR_W    = 17;
   localparam int DATA_W    = 36;
   localparam int NUM_BYTES = 4;
   localparam int BURST_W   = 2;

   // =====================================================================
   // pin encodings
   localparam logic ORDER_LINEAR      = 1'h0;
   localparam logic ORDER_INTERLEAVED = 1'h1;
   localparam logic CMD_LOAD          = 1'h0;
   localparam logic CMD_READ          = 1'h1;
   localparam logic SEL_LOW_ACTIVE    = 1'h0;
   localparam logic SEL_HIGH_ACTIVE   = 1'h1;
   localparam logic GATE_STALL        = 1'h1;

   // =====================================================================
   // timing
   localparam int CLK_PERIOD_NS             = 25;
   localparam int SLEEP_ENTRY_BLANK_TIME_NS = 25;
   localparam int SLEEP_EXIT_RECOVERY_TIME_NS = 25;
   // longest times round down
   localparam int SLEEP_ENTRY_BLANK_CYC =
      SLEEP_ENTRY_BLANK_TIME_NS / CLK_PERIOD_NS;
   localparam int SLEEP_EXIT_RECOVERY_CYC =
      SLEEP_EXIT_RECOVERY_TIME_NS / CLK_PERIOD_NS;

   // =====================================================================
   // operation held for the data phase
   typedef enum logic [1:0] {
      OP_IDLE,
      OP_READ,
      OP_WRITE
   } ssc_op_e;

   // burst position carrier
   typedef struct packed {
      logic               order;
      logic [BURST_W-1:0] base_lo;
      logic [BURST_W-1:0] cnt;
   } ssc_burst_s;

endpackage

// ===== design/ssc_array.sv
`timescale 1ns/100ps

module ssc_array #(
   parameter int ADDR_W    = ssc_pkg::ADDR_W,
   parameter int DATA_W    = ssc_pkg::DATA_W,
   parameter int NUM_BYTES = ssc_pkg::NUM_BYTES
) (
   input  wire logic                  core_clk_i,
   input  wire logic                  wr_en_i,
   input  wire logic [ADDR_W-1:0]     wr_addr_i,
   input  wire logic [NUM_BYTES-1:0]  wr_byte_i,
   input  wire logic [DATA_W-1:0]     wr_data_i,
   input  wire logic [ADDR_W-1:0]     rd_addr_i,
   output logic      [DATA_W-1:0]     rd_data_o
);

   localparam int LANE_W = DATA_W / NUM_BYTES;

   if (DATA_W % NUM_BYTES != 0) begin : g_chk
      $error("data width must split into whole byte lanes");
   end

   logic [DATA_W-1:0] mem_r [2**ADDR_W];

   // =====================================================================
   // byte-lane write, flow-through read
   always_ff @(posedge core_clk_i) begin
      for (int b = 0; b < NUM_BYTES; b++) begin
         if (wr_en_i && wr_byte_i[b]) begin
            mem_r[wr_addr_i][b*LANE_W +: LANE_W] <=
               wr_data_i[b*LANE_W +: LANE_W];
         end
      end
   end

   assign rd_data_o = mem_r[rd_addr_i];

endmodule

// ===== design/ssc_sram_ctrl.sv
`timescale 1ns/100ps

// Summary of operation
// - sleep input high keeps device deselected in low-power sleep.
// - asleep, all inputs but sleep ignored, data outputs high impedance.
// - sleep input acts asynchronously, active high, independent of clock.
// - inputs stop being honoured within one clock after sleep rises.
// - synchronous inputs sampled again within one clock after sleep falls.
// - load edge with read_not_write low starts write, high starts read.
// - chip select active only for selects 0, 0 and 1.
// - burst-order pin 0 gives linear order, 1 gives interleaved.
// - read of uncommitted write returns newest data from input register.
// - gate high pauses that edge and no array write occurs.
// - 2-bit burst counter advances on continue, wraps after fourth access.
// - stalled edge keeps operation, address and burst position unchanged.
// - stall keeps bus driven during read, high impedance during write.

module ssc_sram_ctrl #(
   parameter int ADDR_W    = ssc_pkg::ADDR_W,
   parameter int DATA_W    = ssc_pkg::DATA_W,
   parameter int NUM_BYTES = ssc_pkg::NUM_BYTES
) (
   input  wire logic                 core_clk_i,
   input  wire logic                 arst_n_i,
   input  wire logic                 sleep_request_i,
   input  wire logic                 advance_or_load_n_i,
   input  wire logic                 read_not_write_i,
   input  wire logic                 select_low_primary_i,
   input  wire logic                 select_low_secondary_i,
   input  wire logic                 select_high_secondary_i,
   input  wire logic                 edge_gate_n_i,
   input  wire logic                 burst_order_i,
   input  wire logic                 out_enable_n_i,
   input  wire logic [ADDR_W-1:0]    addr_i,
   input  wire logic [NUM_BYTES-1:0] byte_wr_n_i,
   input  wire logic [DATA_W-1:0]    data_i,
   output logic      [DATA_W-1:0]    data_o,
   output logic                      data_oe_o,
   output logic                      asleep_o
);

   localparam int BW     = ssc_pkg::BURST_W;
   localparam int LANE_W = DATA_W / NUM_BYTES;

   // =====================================================================
   // elaboration checks
   if (ADDR_W <= BW) begin : g_chk_addr
      $error("address must be wider than the burst counter");
   end
   if (NUM_BYTES < 1 || DATA_W % NUM_BYTES != 0) begin : g_chk_lane
      $error("data width must split into whole byte lanes");
   end
   if (ssc_pkg::SLEEP_ENTRY_BLANK_CYC < 1) begin : g_chk_entry
      $error("sleep entry blanking must last at least one cycle");
   end
   if (ssc_pkg::SLEEP_EXIT_RECOVERY_CYC < 1) begin : g_chk_exit
      $error("sleep exit recovery must last at least one cycle");
   end

   typedef struct packed {
      logic                 asleep;
      ssc_pkg::ssc_op_e     op;
      ssc_pkg::ssc_burst_s  burst;
      logic [ADDR_W-1:0]    base;
      logic [NUM_BYTES-1:0] be_n;
      logic                 pend;
      logic [ADDR_W-1:0]    waddr;
      logic [NUM_BYTES-1:0] wbe;
      logic [DATA_W-1:0]    wdata;
      logic [DATA_W-1:0]    dout;
      logic                 doe;
   } ssc_state_s;

   localparam ssc_state_s ST_RESET = '0;
   localparam ssc_state_s ST_SLEEP = '{
      asleep:  1'h1,
      op:      ssc_pkg::OP_IDLE,
      default: '0
   };

   ssc_state_s        st_r;
   ssc_state_s        st_nxt;
   logic              array_we;
   logic [ADDR_W-1:0] cur_addr;
   logic [DATA_W-1:0] array_rd;
   logic              live_edge;
   logic              load_edge;
   logic              sel_ok;

   // =====================================================================
   // helpers
   function automatic logic [BW-1:0] burst_lo(
      input ssc_pkg::ssc_burst_s b);
      if (b.order == ssc_pkg::ORDER_INTERLEAVED) begin
         burst_lo = b.base_lo ^ b.cnt;
      end else begin
         burst_lo = BW'(b.base_lo + b.cnt);
      end
   endfunction

   function automatic logic chip_sel(input logic lp, input logic ls,
                                     input logic hs);
      chip_sel = (lp == ssc_pkg::SEL_LOW_ACTIVE) &&
                 (ls == ssc_pkg::SEL_LOW_ACTIVE) &&
                 (hs == ssc_pkg::SEL_HIGH_ACTIVE);
   endfunction

   // newest data per lane: pending input register over array contents
   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] arr, input ssc_state_s s,
      input logic [ADDR_W-1:0] a);
      merge = arr;
      for (int b = 0; b < NUM_BYTES; b++) begin
         if (s.pend && s.waddr == a && s.wbe[b]) begin
            merge[b*LANE_W +: LANE_W] = s.wdata[b*LANE_W +: LANE_W];
         end
      end
   endfunction

   // full address of the current beat: upper bits stay, low bits count
   function automatic logic [ADDR_W-1:0] burst_addr(
      input logic [ADDR_W-1:0] base, input ssc_pkg::ssc_burst_s b);
      burst_addr = {base[ADDR_W-1:BW], burst_lo(b)};
   endfunction

   // the direction pin picks read or write on a load edge
   function automatic ssc_pkg::ssc_op_e load_op(input logic rnw);
      if (rnw == ssc_pkg::CMD_READ) begin
         load_op = ssc_pkg::OP_READ;
      end else begin
         load_op = ssc_pkg::OP_WRITE;
      end
   endfunction

   // =====================================================================
   // edge qualifiers
   assign cur_addr  = burst_addr(st_r.base, st_r.burst);
   // an edge counts only when it is neither gated nor inside sleep
   assign live_edge = (edge_gate_n_i != ssc_pkg::GATE_STALL) &&
                      !sleep_request_i;
   assign load_edge = live_edge &&
                      (advance_or_load_n_i == ssc_pkg::CMD_LOAD);
   assign sel_ok    = chip_sel(select_low_primary_i,
                               select_low_secondary_i,
                               select_high_secondary_i);

   // =====================================================================
   // next state
   always_comb begin
      st_nxt   = st_r;
      array_we = 1'h0;
      // gated edge or sleep: nothing moves, no array write
      if (live_edge) begin
         st_nxt.asleep = 1'h0;
         array_we      = st_r.pend;
         st_nxt.pend   = 1'h0;
         // data phase of the operation loaded at the previous edge
         case (st_r.op)
            ssc_pkg::OP_READ: begin
               st_nxt.dout = merge(array_rd, st_r, cur_addr);
               st_nxt.doe  = !out_enable_n_i;
            end
            ssc_pkg::OP_WRITE: begin
               st_nxt.waddr = cur_addr;
               st_nxt.wbe   = ~st_r.be_n;
               st_nxt.wdata = data_i;
               st_nxt.pend  = |(~st_r.be_n);
               st_nxt.doe   = 1'h0;
            end
            default: begin
               st_nxt.doe = 1'h0;
            end
         endcase
         // address phase of a new cycle
         st_nxt.be_n = byte_wr_n_i;
         if (load_edge) begin
            if (sel_ok) begin
               st_nxt.op = load_op(read_not_write_i);
               st_nxt.base          = addr_i;
               st_nxt.burst.order   = burst_order_i;
               st_nxt.burst.base_lo = addr_i[BW-1:0];
               st_nxt.burst.cnt     = '0;
            end else begin
               st_nxt.op = ssc_pkg::OP_IDLE;
            end
         end else if (st_r.op != ssc_pkg::OP_IDLE) begin
            st_nxt.burst.cnt = BW'(st_r.burst.cnt + 1'h1);
         end
      end
   end

   // =====================================================================
   // state register; sleep forces the deselected sleep state at once
   always_ff @(posedge core_clk_i or negedge arst_n_i
               or posedge sleep_request_i) begin
      if (!arst_n_i) begin
         st_r <= ST_RESET;
      end else if (sleep_request_i) begin
         st_r <= ST_SLEEP;
      end else begin
         st_r <= st_nxt;
      end
   end

   ssc_array #(
      .ADDR_W    (ADDR_W),
      .DATA_W    (DATA_W),
      .NUM_BYTES (NUM_BYTES)
   ) u_array (
      .core_clk_i (core_clk_i),
      .wr_en_i    (array_we),
      .wr_addr_i  (st_r.waddr),
      .wr_byte_i  (st_r.wbe),
      .wr_data_i  (st_r.wdata),
      .rd_addr_i  (cur_addr),
      .rd_data_o  (array_rd)
   );

   assign data_o    = st_r.dout;
   assign data_oe_o = st_r.doe;
   assign asleep_o  = st_r.asleep;

endmodule

// ===== testbench/ssc_sram_ctrl_asserts.sv
`timescale 1ns/100ps

module ssc_sram_ctrl_asserts #(
   parameter int DATA_W = ssc_pkg::DATA_W
) (
   input wire logic              core_clk_i,
   input wire logic              arst_n_i,
   input wire logic              sleep_request_i,
   input wire logic              advance_or_load_n_i,
   input wire logic              read_not_write_i,
   input wire logic              select_low_primary_i,
   input wire logic              select_low_secondary_i,
   input wire logic              select_high_secondary_i,
   input wire logic              edge_gate_n_i,
   input wire logic              out_enable_n_i,
   input wire logic [DATA_W-1:0] data_o,
   input wire logic              data_oe_o,
   input wire logic              asleep_o
);
   wire logic go  = !edge_gate_n_i && !sleep_request_i;
   wire logic ld  = go && !advance_or_load_n_i;
   wire logic sel = !select_low_primary_i && !select_low_secondary_i
                    && select_high_secondary_i;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   property p_held; sleep_request_i |-> asleep_o; endproperty
   a_held: assert property (p_held)
      else $error("sleep input high but not asleep");
   property p_hiz; asleep_o |-> !data_oe_o; endproperty
   a_hiz: assert property (p_hiz)
      else $error("bus driven while asleep");
   property p_enter; $rose(sleep_request_i) |-> asleep_o && !data_oe_o;
   endproperty
   a_enter: assert property (p_enter)
      else $error("sleep entry too slow");
   property p_wake; asleep_o && go ##1 !sleep_request_i |-> !asleep_o;
   endproperty
   a_wake: assert property (p_wake)
      else $error("sleep not left on first active edge");
   property p_read; ld && read_not_write_i && sel ##1 go && !out_enable_n_i
      ##1 !sleep_request_i |-> data_oe_o; endproperty
   a_read: assert property (p_read)
      else $error("read did not drive bus");
   property p_write; ld && !read_not_write_i ##1 go ##1 !sleep_request_i
      |-> !data_oe_o; endproperty
   a_write: assert property (p_write)
      else $error("bus driven in write data phase");
   property p_desel; ld && !sel ##1 go ##1 !sleep_request_i |-> !data_oe_o;
   endproperty
   a_desel: assert property (p_desel)
      else $error("bus driven after deselect");
   property p_stall; edge_gate_n_i && !sleep_request_i ##1 !sleep_request_i
      |-> $stable(data_o) && $stable(data_oe_o); endproperty
   a_stall: assert property (p_stall)
      else $error("outputs changed on stalled edge");

   c_read: cover property (ld && read_not_write_i && sel);
   c_stall: cover property (edge_gate_n_i && data_oe_o);
   c_sleep: cover property ($rose(sleep_request_i));
endmodule

bind ssc_sram_ctrl ssc_sram_ctrl_asserts #(.DATA_W(DATA_W))
   ssc_sram_ctrl_asserts_inst (.core_clk_i, .arst_n_i, .sleep_request_i,
   .advance_or_load_n_i, .read_not_write_i, .select_low_primary_i,
   .select_low_secondary_i, .select_high_secondary_i, .edge_gate_n_i,
   .out_enable_n_i, .data_o, .data_oe_o, .asleep_o);

// ===== testbench/ssc_host_model.sv
`timescale 1ns/100ps

module ssc_host_model (
   input  wire logic   clk_i,
   output logic        sleep_o = 1'h0,
   output logic        adv_o   = 1'h1,
   output logic        rnw_o   = 1'h1,
   output logic        order_o = 1'h0,
   output logic        gate_o  = 1'h0,
   output logic [2:0]  sel_o   = 3'h5,
   output logic [16:0] addr_o  = 17'h0,
   output logic [35:0] data_o  = 36'h0
);
   logic        wph = 1'h0;
   logic [35:0] wd  = 36'h0;

   // data bus is only meaningful one cycle after a write load
   task automatic cyc(input logic [6:0] k, input logic [16:0] a,
                      input logic [35:0] d);
      @(posedge clk_i);
      {adv_o, rnw_o, order_o, gate_o, sel_o} <= k;
      addr_o <= a;
      data_o <= wph ? wd : ~data_o;
      // a stalled edge keeps the write data waiting for the next live edge
      if (!k[3]) begin
         wph = (k == 7'h01);
         wd  = d;
      end
   endtask

   // raised only when no read or write is outstanding
   task automatic slp(input logic v);
      sleep_o = v;
   endtask
endmodule

// ===== testbench/ssc_sram_ctrl_tb_top.sv
`timescale 1ns/100ps

module ssc_sram_ctrl_tb_top;
   localparam logic [6:0] RD = 7'h21, RI = 7'h31, WR = 7'h01;
   localparam logic [6:0] NP = 7'h05, CT = 7'h40, ST = 7'h48;
   logic              core_clk    = 1'h0;
   logic              arst_n      = 1'h0;
   int                fails       = 0;
   int                checks_done = 0;
   wire logic         slp, adv, rnw, ord, gate, oe, asleep;
   wire logic [2:0]   sel;
   wire logic [16:0]  addr;
   wire logic [35:0]  wdat, rdat;

   always #12.5 core_clk = ~core_clk;

   ssc_host_model ssc_host_model_inst (.clk_i(core_clk), .sleep_o(slp),
      .adv_o(adv), .rnw_o(rnw), .order_o(ord), .gate_o(gate),
      .sel_o(sel), .addr_o(addr), .data_o(wdat));
   ssc_sram_ctrl ssc_sram_ctrl_inst (.core_clk_i(core_clk),
      .arst_n_i(arst_n), .sleep_request_i(slp), .advance_or_load_n_i(adv),
      .read_not_write_i(rnw), .select_low_primary_i(sel[2]),
      .select_low_secondary_i(sel[1]), .select_high_secondary_i(sel[0]),
      .edge_gate_n_i(gate), .burst_order_i(ord), .out_enable_n_i(1'h0),
      .addr_i(addr), .byte_wr_n_i(4'h0), .data_i(wdat), .data_o(rdat),
      .data_oe_o(oe), .asleep_o(asleep));

   task automatic cmp(input string n, input logic [35:0] e, g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic cy(input logic [6:0] k, input logic [16:0] a = 17'h0,
                     input logic [35:0] d = 36'h0);
      ssc_host_model_inst.cyc(k, a, d);
   endtask

   task automatic t_burst;
      logic [1:0] lo;
      for (int i = 0; i < 4; i++) cy(WR, 17'h10 + i, 36'h100 + i);
      cy(NP);
      for (int o = 0; o < 2; o++) begin
         cy(o[0] ? RI : RD, 17'h11);
         cy(CT);
         for (int j = 0; j < 5; j++) begin
            cy(j < 4 ? CT : NP);
            lo = o[0] ? 2'h1 ^ j[1:0] : 2'h1 + j[1:0];
            #1 cmp("burst", {34'h40, lo}, rdat);
         end
      end
   endtask

   task automatic t_bypass;
      cy(WR, 17'h30, 36'h9a5);
      cy(RD, 17'h30);
      cy(NP);
      #1 cmp("oe", 36'h0, 36'(oe));
      cy(NP);
      #1 cmp("bypass", 36'h9a5, rdat);
      cmp("oe", 36'h1, 36'(oe));
   endtask

   task automatic t_stall;
      cy(RD, 17'h12);
      cy(ST);
      cy(CT);
      #1 cmp("oe", 36'h0, 36'(oe));
      cy(ST);
      cy(NP);
      #1 cmp("oe", 36'h1, 36'(oe));
      cmp("stall", 36'h102, rdat);
      cy(NP);
      #1 cmp("stall", 36'h103, rdat);
      cy(WR, 17'h20, 36'h5c3);
      cy(ST);
      cy(RD, 17'h20);
      #1 cmp("oe", 36'h0, 36'(oe));
      cy(NP);
      cy(NP);
      #1 cmp("stall", 36'h5c3, rdat);
   endtask

   task automatic t_select;
      for (int s = 0; s < 8; s++) begin
         cy({4'h4, s[2:0]}, 17'h10);
         cy(NP);
         cy(NP);
         #1 cmp("select", 36'(s == 1), 36'(oe));
      end
   endtask

   task automatic t_sleep;
      cy(RD, 17'h13);
      cy(NP);
      cy(NP);
      // sleep moves off the clock edge to show it needs no edge
      #8 ssc_host_model_inst.slp(1'h1);
      #1 cmp("oe", 36'h0, 36'(oe));
      cmp("asleep", 36'h1, 36'(asleep));
      cy(WR, 17'h13);
      cy(NP);
      #1 cmp("asleep", 36'h1, 36'(asleep));
      ssc_host_model_inst.slp(1'h0);
      cy(RD, 17'h13);
      #1 cmp("asleep", 36'h0, 36'(asleep));
      cy(NP);
      cy(NP);
      #1 cmp("wake", 36'h103, rdat);
   endtask

   initial begin
      repeat (20) @(posedge core_clk);
      arst_n <= 1'h1;
      t_burst;
      t_bypass;
      t_stall;
      t_select;
      t_sleep;
      close_out;
   end

   // watchdog, about ten times the expected run
   initial begin
      repeat (1000) @(posedge core_clk);
      fails++;
      close_out;
   end
endmodule
